//--- shared/pmx_map.svh
// register offsets, field positions, vectors and reset values
// assumes 32-bit apb data, byte addresses on an 8-bit paddr
`ifndef PMX_MAP_SVH
`define PMX_MAP_SVH
// ********************************
// register offsets
// ********************************
`define PMX_A_CNT0      8'h00
`define PMX_A_CTL0      8'h10
`define PMX_A_CTL1      8'h14
`define PMX_A_SIA       8'h18
`define PMX_A_INSTR_BREAKPOINT_ADDR      8'h1C
`define PMX_A_MSR       8'h20
`define PMX_A_SAVE_RESTORE_PC      8'h24
`define PMX_A_SAVE_RESTORE_STATUS      8'h28
`define PMX_A_UCNT0     8'h40
`define PMX_A_UCTL0     8'h50
`define PMX_A_UCTL1     8'h54
`define PMX_A_USER_SAMPLED_ADDRESS_VIEW      8'h58
`define PMX_A_STEP      8'h04
// ********************************
// vectors
// ********************************
`define PMX_VEC_PM      32'h0000_0F00
`define PMX_VEC_BP      32'h0000_1300
`define PMX_VEC_HIGH    32'hFFF0_0000
`define PMX_VEC_LOW     32'h0000_0000
// ********************************
// machine state bits (bit 0 is lsb)
// ********************************
`define PMX_MSR_POW     18
`define PMX_MSR_ILE     16
`define PMX_MSR_EE      15
`define PMX_MSR_PR      14
`define PMX_MSR_FP      13
`define PMX_MSR_ME      12
`define PMX_MSR_FE0     11
`define PMX_MSR_SE      10
`define PMX_MSR_BE      9
`define PMX_MSR_FE1     8
`define PMX_MSR_IP      6
`define PMX_MSR_IR      5
`define PMX_MSR_DR      4
`define PMX_MSR_PM      2
`define PMX_MSR_RI      1
`define PMX_MSR_LE      0
`define PMX_SAVE_RESTORE_STATUS_KEEP   32'h87C0_FFFF
`define PMX_MSR_RST     32'h0000_0000
// ********************************
// control and breakpoint fields
// ********************************
`define PMX_CTL0_FRZ    0
`define PMX_CTL0_PMIE   1
`define PMX_CTL0_CIE    4
`define PMX_CTL1_SELW   3
`define PMX_INSTR_BREAKPOINT_ADDR_BE     0
`define PMX_INSTR_BREAKPOINT_ADDR_TE     1
`define PMX_INSTR_BREAKPOINT_ADDR_ALSB   2
`endif

//--- shared/pmx_pkg.sv
// types shared by the exception unit and its bench
// assumes nothing beyond the map header
package pmx_pkg;
	typedef enum logic [1:0] {
		PMX_CAUSE_NONE,
		PMX_CAUSE_PM,
		PMX_CAUSE_BP
	} pmx_cause_t;
	typedef struct packed {
		logic        valid;
		pmx_cause_t  cause;
		logic [31:0] addr;
	} pmx_redirect_t;
endpackage

//--- src/pmx_brk_match.sv
// instruction address breakpoint comparator
// assumes ea is the next instruction to complete
`timescale 1ns/1ps
`include "pmx_map.svh"
module pmx_brk_match (
	input  wire logic        valid,
	input  wire logic [31:0] bp_word,
	input  wire logic [31:0] ea,
	input  wire logic        itrans,
	output logic             hit
);
	logic addr_eq;
	logic te_eq;
	assign addr_eq = bp_word[31:`PMX_INSTR_BREAKPOINT_ADDR_ALSB] == ea[31:`PMX_INSTR_BREAKPOINT_ADDR_ALSB];
	assign te_eq = bp_word[`PMX_INSTR_BREAKPOINT_ADDR_TE] == itrans;
	assign hit = valid & addr_eq & te_eq & bp_word[`PMX_INSTR_BREAKPOINT_ADDR_BE];
endmodule

//--- src/pmx_event_counter.sv
// one event counter with software load
// assumes count_en is already gated by freeze and event select
`timescale 1ns/1ps
module pmx_event_counter #(
	parameter int W = 32
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         wr_en,
	input  wire logic [W-1:0] wr_data,
	input  wire logic         count_en,
	output logic      [W-1:0] value,
	output logic              ovf
);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;
	// software load beats a same-cycle count
	assign cnt_next = wr_en ? wr_data : (count_en ? cnt_reg + 1'b1 : cnt_reg);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end
	assign value = cnt_reg;
	// msb set is the overflow condition
	assign ovf = cnt_reg[W-1];
endmodule

//--- src/pmx_exc_unit.sv
// monitor interrupt and address breakpoint exception entry
// assumes core holds completion while complete_hold is high
// and that apb accesses come from a supervisor agent
`timescale 1ns/1ps
`include "pmx_map.svh"
module pmx_exc_unit #(
	parameter int NCNT = 4,
	parameter int NEVT = 8
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [NEVT-1:0]       evt_in,
	input  wire logic [31:0]           sample_ea,
	input  wire logic [31:0]           next_ea,
	input  wire logic                  cmp_valid,
	input  wire logic [31:0]           cmp_ea,
	input  wire logic                  ext_irq_pend,
	input  wire logic                  trace_pend,
	input  wire logic                  soft_stop_en,
	output logic                       complete_hold,
	output logic                       trace_suppress,
	output logic                       dec_defer,
	output logic                       cop_bp_match,
	output logic                       soft_stop,
	output logic      [31:0]           msr_out,
	output pmx_pkg::pmx_redirect_t     redirect
);
	// ********************************
	// declarations
	// ********************************
	localparam int SW = `PMX_CTL1_SELW;
	logic [31:0]            ctl0_reg;
	logic [31:0]            ctl1_reg;
	logic [31:0]            sia_reg;
	logic [31:0]            instr_breakpoint_addr_reg;
	logic [31:0]            instr_breakpoint_addr_act_reg;
	logic                   instr_breakpoint_addr_dirty_reg;
	logic [31:0]            msr_reg;
	logic [31:0]            msr_next;
	logic [31:0]            save_restore_pc_reg;
	logic [31:0]            save_restore_status_reg;
	logic                   pm_cond_reg;
	logic                   pm_pend_reg;
	logic [31:0]            rdata_reg;
	logic [31:0]            rdata_next;
	pmx_pkg::pmx_redirect_t redir_reg;
	logic [31:0]            cnt_val [NCNT];
	logic [NCNT-1:0]        cnt_ovf;
	logic [NCNT-1:0]        cnt_hit;
	logic [NCNT-1:0]        ucnt_hit;
	logic                   wr_acc;
	logic                   acc;
	logic                   setup;
	logic                   ctl0_hit;
	logic                   ctl1_hit;
	logic                   sia_hit;
	logic                   instr_breakpoint_addr_hit;
	logic                   msr_hit;
	logic                   save_restore_pc_hit;
	logic                   save_restore_status_hit;
	logic                   user_hit;
	logic                   any_hit;
	logic                   bp_raw;
	logic                   bp_exc;
	logic                   pm_cond;
	logic                   pm_rise;
	logic                   pm_take;
	logic                   take;
	logic                   retire;
	logic [31:0]            vec_base;
	logic [31:0]            msr_clr;

	// ********************************
	// apb decode
	// ********************************
	assign setup = psel & ~penable;
	assign acc = psel & penable;
	assign wr_acc = acc & pwrite;
	assign ctl0_hit = paddr == `PMX_A_CTL0;
	assign ctl1_hit = paddr == `PMX_A_CTL1;
	assign sia_hit = paddr == `PMX_A_SIA;
	assign instr_breakpoint_addr_hit = paddr == `PMX_A_INSTR_BREAKPOINT_ADDR;
	assign msr_hit = paddr == `PMX_A_MSR;
	assign save_restore_pc_hit = paddr == `PMX_A_SAVE_RESTORE_PC;
	assign save_restore_status_hit = paddr == `PMX_A_SAVE_RESTORE_STATUS;
	assign user_hit = (|ucnt_hit) | (paddr == `PMX_A_UCTL0)
		| (paddr == `PMX_A_UCTL1) | (paddr == `PMX_A_USER_SAMPLED_ADDRESS_VIEW);
	assign any_hit = user_hit | (|cnt_hit) | ctl0_hit | ctl1_hit | sia_hit
		| instr_breakpoint_addr_hit | msr_hit | save_restore_pc_hit | save_restore_status_hit;
	// zero wait states; user views refuse writes
	assign pready = acc;
	assign pslverr = acc & (~any_hit | (pwrite & user_hit));

	// ********************************
	// event counters
	// ********************************
	genvar gi;
	generate
		for (gi = 0; gi < NCNT; gi++) begin : g_cnt
			logic [SW-1:0] sel;
			logic          cnt_en;
			assign cnt_hit[gi] = paddr == (`PMX_A_CNT0
				+ 8'(gi) * `PMX_A_STEP);
			assign ucnt_hit[gi] = paddr == (`PMX_A_UCNT0
				+ 8'(gi) * `PMX_A_STEP);
			assign sel = ctl1_reg[gi*SW +: SW];
			// selected event: clocks, misses, dispatches, mispredicts
			assign cnt_en = ~ctl0_reg[`PMX_CTL0_FRZ]
				& evt_in[sel];
			pmx_event_counter #(
				.W(32)
			) u_cnt (
				.pclk    (pclk),
				.presetn (presetn),
				.wr_en   (wr_acc & cnt_hit[gi]),
				.wr_data (pwdata),
				.count_en(cnt_en),
				.value   (cnt_val[gi]),
				.ovf     (cnt_ovf[gi])
			);
		end
	endgenerate

	// ********************************
	// read mux
	// ********************************
	always_comb begin
		rdata_next = 32'h0000_0000;
		for (int i = 0; i < NCNT; i++) begin
			if (cnt_hit[i] | ucnt_hit[i]) begin
				rdata_next = cnt_val[i];
			end
		end
		if (ctl0_hit | (paddr == `PMX_A_UCTL0)) begin
			rdata_next = ctl0_reg;
		end else if (ctl1_hit | (paddr == `PMX_A_UCTL1)) begin
			rdata_next = ctl1_reg;
		end else if (sia_hit | (paddr == `PMX_A_USER_SAMPLED_ADDRESS_VIEW)) begin
			rdata_next = sia_reg;
		end else if (instr_breakpoint_addr_hit) begin
			rdata_next = instr_breakpoint_addr_reg;
		end else if (msr_hit) begin
			rdata_next = msr_reg;
		end else if (save_restore_pc_hit) begin
			rdata_next = save_restore_pc_reg;
		end else if (save_restore_status_hit) begin
			rdata_next = save_restore_status_reg;
		end
	end
	// read data is caught in the setup cycle so it leaves a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_reg <= 32'h0000_0000;
		end else if (setup & ~pwrite) begin
			rdata_reg <= rdata_next;
		end
	end
	assign prdata = rdata_reg;

	// ********************************
	// monitor interrupt condition
	// ********************************
	assign pm_cond = ctl0_reg[`PMX_CTL0_PMIE]
		& |(cnt_ovf & ctl0_reg[`PMX_CTL0_CIE +: NCNT]);
	assign pm_rise = pm_cond & ~pm_cond_reg;
	// ext pending or ee clear keeps the request parked
	assign pm_take = pm_pend_reg & msr_reg[`PMX_MSR_EE]
		& ~ext_irq_pend & ~bp_exc;
	// decrementer logic must wait while this one is takeable
	assign dec_defer = pm_pend_reg & msr_reg[`PMX_MSR_EE];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pm_cond_reg <= 1'b0;
			pm_pend_reg <= 1'b0;
		end else begin
			pm_cond_reg <= pm_cond;
			// a new rise in the take cycle stays pending
			pm_pend_reg <= pm_rise | (pm_pend_reg & ~pm_take);
		end
	end

	// ********************************
	// breakpoint
	// ********************************
	pmx_brk_match u_brk (
		.valid  (cmp_valid),
		.bp_word(instr_breakpoint_addr_act_reg),
		.ea     (cmp_ea),
		.itrans (msr_reg[`PMX_MSR_IR]),
		.hit    (bp_raw)
	);
	assign complete_hold = bp_raw;
	assign cop_bp_match = bp_raw;
	assign trace_suppress = bp_raw & trace_pend;
	assign soft_stop = bp_raw & soft_stop_en;
	assign bp_exc = bp_raw & ~soft_stop_en;
	assign retire = cmp_valid & ~complete_hold;
	// the compare keeps the old word until one more instruction
	// retires, which is the sync that software places after the write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_breakpoint_addr_reg <= 32'h0000_0000;
			instr_breakpoint_addr_act_reg <= 32'h0000_0000;
			instr_breakpoint_addr_dirty_reg <= 1'b0;
		end else begin
			if (wr_acc & instr_breakpoint_addr_hit) begin
				instr_breakpoint_addr_reg <= pwdata;
			end
			if (retire & instr_breakpoint_addr_dirty_reg) begin
				instr_breakpoint_addr_act_reg <= instr_breakpoint_addr_reg;
			end
			instr_breakpoint_addr_dirty_reg <= (wr_acc & instr_breakpoint_addr_hit)
				| (instr_breakpoint_addr_dirty_reg & ~retire);
		end
	end

	// ********************************
	// exception entry
	// ********************************
	assign take = bp_exc | pm_take;
	assign vec_base = msr_reg[`PMX_MSR_IP] ? `PMX_VEC_HIGH : `PMX_VEC_LOW;
	assign msr_clr = (32'h1 << `PMX_MSR_POW) | (32'h1 << `PMX_MSR_EE)
		| (32'h1 << `PMX_MSR_PR) | (32'h1 << `PMX_MSR_FP)
		| (32'h1 << `PMX_MSR_FE0) | (32'h1 << `PMX_MSR_SE)
		| (32'h1 << `PMX_MSR_BE) | (32'h1 << `PMX_MSR_FE1)
		| (32'h1 << `PMX_MSR_IR) | (32'h1 << `PMX_MSR_DR)
		| (32'h1 << `PMX_MSR_PM) | (32'h1 << `PMX_MSR_RI)
		| (32'h1 << `PMX_MSR_LE);
	always_comb begin
		msr_next = msr_reg & ~msr_clr;
		msr_next[`PMX_MSR_LE] = msr_reg[`PMX_MSR_ILE];
	end
	// entry beats a same-cycle software write to the saved state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			msr_reg <= `PMX_MSR_RST;
			save_restore_pc_reg <= 32'h0000_0000;
			save_restore_status_reg <= 32'h0000_0000;
		end else if (take) begin
			msr_reg <= msr_next;
			save_restore_pc_reg <= bp_exc ? cmp_ea : next_ea;
			save_restore_status_reg <= msr_reg & `PMX_SAVE_RESTORE_STATUS_KEEP;
		end else begin
			if (wr_acc & msr_hit) begin
				msr_reg <= pwdata;
			end
			if (wr_acc & save_restore_pc_hit) begin
				save_restore_pc_reg <= pwdata;
			end
			if (wr_acc & save_restore_status_hit) begin
				save_restore_status_reg <= pwdata;
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			redir_reg <= '0;
		end else begin
			redir_reg.valid <= take;
			redir_reg.cause <= bp_exc ? pmx_pkg::PMX_CAUSE_BP
				: (pm_take ? pmx_pkg::PMX_CAUSE_PM
				: pmx_pkg::PMX_CAUSE_NONE);
			redir_reg.addr <= vec_base
				| (bp_exc ? `PMX_VEC_BP : `PMX_VEC_PM);
		end
	end
	assign redirect = redir_reg;
	assign msr_out = msr_reg;

	// ********************************
	// control registers and sample
	// ********************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl0_reg <= 32'h0000_0000;
			ctl1_reg <= 32'h0000_0000;
			sia_reg <= 32'h0000_0000;
		end else begin
			if (wr_acc & ctl0_hit) begin
				ctl0_reg <= pwdata;
			end
			if (wr_acc & ctl1_hit) begin
				ctl1_reg <= pwdata;
			end
			// hardware capture beats a software write
			if (pm_rise) begin
				sia_reg <= sample_ea;
			end else if (wr_acc & sia_hit) begin
				sia_reg <= pwdata;
			end
		end
	end

	// ********************************
	// checks
	// ********************************
	chk_pm_vector: assert property (
		@(posedge pclk) disable iff (!presetn)
		pm_take |=> redirect.valid && redirect.addr ==
			($past(vec_base) | `PMX_VEC_PM))
		else $error("monitor vector wrong");
	chk_bp_vector: assert property (
		@(posedge pclk) disable iff (!presetn)
		bp_exc |=> redirect.valid && redirect.addr ==
			($past(vec_base) | `PMX_VEC_BP))
		else $error("breakpoint vector wrong");
	chk_pm_below_ext: assert property (
		@(posedge pclk) disable iff (!presetn)
		ext_irq_pend |=> !(redirect.cause == pmx_pkg::PMX_CAUSE_PM))
		else $error("monitor taken over external");
	chk_save_restore_status_fill: assert property (
		@(posedge pclk) disable iff (!presetn)
		take |=> save_restore_status_reg == ($past(msr_reg) & `PMX_SAVE_RESTORE_STATUS_KEEP))
		else $error("status save wrong");
	chk_msr_entry: assert property (
		@(posedge pclk) disable iff (!presetn)
		take |=> !msr_reg[`PMX_MSR_EE] && !msr_reg[`PMX_MSR_IR]
			&& msr_reg[`PMX_MSR_LE] == $past(msr_reg[`PMX_MSR_ILE])
			&& msr_reg[`PMX_MSR_IP] == $past(msr_reg[`PMX_MSR_IP]))
		else $error("machine state entry wrong");
	chk_save_restore_pc_bp: assert property (
		@(posedge pclk) disable iff (!presetn)
		bp_exc |=> save_restore_pc_reg == $past(cmp_ea))
		else $error("return address wrong");
	chk_bp_hold: assert property (
		@(posedge pclk) disable iff (!presetn)
		(cmp_valid && instr_breakpoint_addr_act_reg[`PMX_INSTR_BREAKPOINT_ADDR_BE]
			&& instr_breakpoint_addr_act_reg[31:`PMX_INSTR_BREAKPOINT_ADDR_ALSB] == cmp_ea[31:`PMX_INSTR_BREAKPOINT_ADDR_ALSB]
			&& instr_breakpoint_addr_act_reg[`PMX_INSTR_BREAKPOINT_ADDR_TE] == msr_reg[`PMX_MSR_IR])
			|-> complete_hold && cop_bp_match)
		else $error("breakpoint hit not held");
	chk_pm_waits: assert property (
		@(posedge pclk) disable iff (!presetn)
		(pm_pend_reg && !msr_reg[`PMX_MSR_EE]) |=> pm_pend_reg)
		else $error("monitor request lost");
	chk_soft_stop: assert property (
		@(posedge pclk) disable iff (!presetn)
		(bp_raw && soft_stop_en) |=> !(redirect.cause
			== pmx_pkg::PMX_CAUSE_BP))
		else $error("soft stop took exception");
	chk_sia_capture: assert property (
		@(posedge pclk) disable iff (!presetn)
		pm_rise |=> sia_reg == $past(sample_ea))
		else $error("sampled address missed");
endmodule

//--- tb/pmx_core_model.sv
// completion side model: presents one instruction per go pulse
// assumes hold and soft stop come from the exception unit
`timescale 1ns/1ps
module pmx_core_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        go,
	input  wire logic [31:0] go_ea,
	input  wire logic        complete_hold,
	input  wire logic        soft_stop,
	output logic             cmp_valid,
	output logic      [31:0] cmp_ea
);
	// ********************************
	// completion slot
	// ********************************
	// a held instruction is flushed by the entry, kept while stopped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_valid <= 1'b0;
			cmp_ea    <= 32'h0;
		end else if (go && !cmp_valid) begin
			cmp_valid <= 1'b1;
			cmp_ea    <= go_ea;
		end else if (cmp_valid && !(complete_hold && soft_stop)) begin
			cmp_valid <= 1'b0;
			// idle address scrambled so a stale match cannot linger
			cmp_ea    <= ~cmp_ea;
		end
	end
endmodule

//--- tb/testbench.sv
// self-checking bench for the monitor and breakpoint entry unit
// assumes the map header on the include path and a 40 MHz pclk
`timescale 1ns/1ps
`include "pmx_map.svh"
module testbench;
	logic                   pclk = 1'b0;
	logic                   presetn = 1'b0;
	logic                   psel, penable, pwrite, pready, pslverr;
	logic                   ext_irq_pend, trace_pend, soft_stop_en;
	logic                   go, hi7, got, err, cmp_valid, soft_stop;
	logic                   complete_hold, trace_suppress, dec_defer;
	logic                   cop_bp_match;
	logic [7:0]             paddr, evt_in;
	logic [31:0]            pwdata, prdata, sample_ea, next_ea, go_ea;
	logic [31:0]            cmp_ea, msr_out, rd, m, mb, v, ea;
	pmx_pkg::pmx_redirect_t redirect;
	int                     n_mismatch, compares, seed;

	always #12.5 pclk = ~pclk;
	// only event 7 is steered by the bench, event 0 is held high, events 1-6 churn at random
	always @(posedge pclk) evt_in <= {hi7, 6'($random(seed)), 1'b1};

	pmx_exc_unit i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .evt_in(evt_in), .sample_ea(sample_ea),
		.next_ea(next_ea), .cmp_valid(cmp_valid), .cmp_ea(cmp_ea),
		.ext_irq_pend(ext_irq_pend), .trace_pend(trace_pend),
		.soft_stop_en(soft_stop_en), .complete_hold(complete_hold),
		.trace_suppress(trace_suppress), .dec_defer(dec_defer),
		.cop_bp_match(cop_bp_match), .soft_stop(soft_stop),
		.msr_out(msr_out), .redirect(redirect));
	pmx_core_model i_core (.pclk(pclk), .presetn(presetn), .go(go),
		.go_ea(go_ea), .complete_hold(complete_hold),
		.soft_stop(soft_stop), .cmp_valid(cmp_valid), .cmp_ea(cmp_ea));

	// ********************************
	// reference model
	// ********************************
	function automatic logic [31:0] base(input logic [31:0] s);
		return s[`PMX_MSR_IP] ? `PMX_VEC_HIGH : `PMX_VEC_LOW;
	endfunction
	function automatic logic [31:0] nmsr(input logic [31:0] s);
		return (s & 32'h0001_1040) | {31'h0, s[`PMX_MSR_ILE]};
	endfunction

	// ********************************
	// bench tasks
	// ********************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		// no wait count assumed; a stuck slave is left to the watchdog
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic wait_rd(input int lim);
		got = 1'b0;
		repeat (lim) begin
			@(posedge pclk);
			if (redirect.valid === 1'b1) begin
				got = 1'b1;
				break;
			end
		end
	endtask
	// one instruction reaches completion; returns inside its cycle
	task automatic issue(input logic [31:0] a);
		@(posedge pclk);
		{go, go_ea} <= {1'b1, a};
		@(posedge pclk);
		go <= 1'b0;
		@(negedge pclk);
	endtask
	task automatic complete_run;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		#(25 * 5000);
		n_mismatch++;
		complete_run();
	end

	// ********************************
	// scenarios
	// ********************************
	initial begin
		seed = 12;
		{psel, penable, pwrite, go, hi7} = 5'h00;
		{ext_irq_pend, trace_pend, soft_stop_en} = 3'h0;
		{paddr, pwdata, go_ea} = '0;
		sample_ea = $random(seed);
		next_ea = $random(seed);
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `PMX_A_MSR, 32'h0);
		chk(rd, `PMX_MSR_RST);
		chk(err, 1'b0);
		apb(1'b0, 8'h3C, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		apb(1'b1, `PMX_A_UCTL0, 32'hFF);
		chk(err, 1'b1);
		apb(1'b1, `PMX_A_CTL0, 32'h1);
		apb(1'b1, `PMX_A_CTL1, 32'h38);
		v = $random(seed) & 32'h7FFF_FFFF;
		apb(1'b1, `PMX_A_CNT0 + 8'h04, v);
		apb(1'b1, `PMX_A_CNT0, 32'h7FFF_FFF0);
		m = $random(seed) & 32'h0005_FF77;
		m[`PMX_MSR_EE] = 1'b0;
		apb(1'b1, `PMX_A_MSR, m);
		ext_irq_pend <= 1'b1;
		apb(1'b1, `PMX_A_CTL0, 32'h12);
		apb(1'b0, `PMX_A_UCTL0, 32'h0);
		chk(rd, 32'h12);
		hi7 <= 1'b1;
		repeat (5) @(posedge pclk);
		hi7 <= 1'b0;
		wait_rd(40);
		chk(got, 1'b0);
		apb(1'b0, `PMX_A_UCNT0 + 8'h04, 32'h0);
		chk(rd, v + 32'h0000_0005);
		apb(1'b0, `PMX_A_SIA, 32'h0);
		chk(rd, sample_ea);
		apb(1'b0, `PMX_A_USER_SAMPLED_ADDRESS_VIEW, 32'h0);
		chk(rd, sample_ea);
		m[`PMX_MSR_EE] = 1'b1;
		apb(1'b1, `PMX_A_MSR, m);
		wait_rd(10);
		chk(got, 1'b0);
		ext_irq_pend <= 1'b0;
		@(negedge pclk);
		chk(dec_defer, 1'b1);
		wait_rd(5);
		chk(got, 1'b1);
		chk(redirect.cause, pmx_pkg::PMX_CAUSE_PM);
		chk(redirect.addr, base(m) | `PMX_VEC_PM);
		chk(msr_out, nmsr(m));
		@(posedge pclk);
		chk(redirect.valid, 1'b0);
		chk(dec_defer, 1'b0);
		apb(1'b0, `PMX_A_SAVE_RESTORE_PC, 32'h0);
		chk(rd, next_ea);
		apb(1'b0, `PMX_A_SAVE_RESTORE_STATUS, 32'h0);
		chk(rd, m & `PMX_SAVE_RESTORE_STATUS_KEEP);
		mb = nmsr(m);
		ea = $random(seed) & 32'hFFFF_FFFC;
		// the sync right after enabling still sees the old, disabled word
		apb(1'b1, `PMX_A_INSTR_BREAKPOINT_ADDR, ea | 32'h1);
		issue(ea);
		chk({complete_hold, cop_bp_match}, 2'b00);
		issue(ea);
		chk(complete_hold, 1'b1);
		chk(cop_bp_match, 1'b1);
		chk(soft_stop, 1'b0);
		wait_rd(3);
		chk(got, 1'b1);
		chk(redirect.cause, pmx_pkg::PMX_CAUSE_BP);
		chk(redirect.addr, base(mb) | `PMX_VEC_BP);
		chk(msr_out, nmsr(mb));
		apb(1'b0, `PMX_A_SAVE_RESTORE_PC, 32'h0);
		chk(rd, ea);
		apb(1'b0, `PMX_A_SAVE_RESTORE_STATUS, 32'h0);
		chk(rd, mb & `PMX_SAVE_RESTORE_STATUS_KEEP);
		{soft_stop_en, trace_pend} <= 2'b11;
		issue(ea);
		chk({soft_stop, trace_suppress}, 2'b11);
		chk(complete_hold, 1'b1);
		wait_rd(6);
		chk(got, 1'b0);
		{soft_stop_en, trace_pend} <= 2'b00;
		wait_rd(5);
		chk(got, 1'b1);
		chk(redirect.addr, base(mb) | `PMX_VEC_BP);
		// translation bit set while translation is off: no match
		apb(1'b1, `PMX_A_INSTR_BREAKPOINT_ADDR, ea | 32'h3);
		issue(ea ^ 32'h4);
		issue(ea);
		chk({complete_hold, cop_bp_match}, 2'b00);
		repeat (4) @(posedge pclk);
		complete_run();
	end
endmodule
